// File: core/spindle_flag_pkg.sv
// shared constants and carriers of the serial spindle flag interface
package spindle_flag_pkg;

  // spindle counts
  localparam int SERIAL_SPINDLE_MAX = 3;
  localparam int ANALOG_SPINDLE_MAX = 2;

  // command byte indices, in the ladder's input signal space
  localparam logic [7:0] SPINDLE1_COMMAND_FLAGS_IDX = 8'h46;
  localparam logic [7:0] SPINDLE2_COMMAND_FLAGS_IDX = 8'h4A;
  localparam logic [7:0] SPINDLE3_COMMAND_FLAGS_IDX = 8'h4E;

  // status byte indices, in the ladder's output signal space
  localparam logic [7:0] SPINDLE1_STATUS_FLAGS_IDX  = 8'h2D;
  localparam logic [7:0] SPINDLE2_STATUS_FLAGS_IDX  = 8'h31;
  localparam logic [7:0] SPINDLE3_STATUS_FLAGS_IDX  = 8'h35;

  // read space select
  localparam logic SPACE_COMMAND = 1'b0;
  localparam logic SPACE_STATUS  = 1'b1;

  // command byte fields
  localparam int CW_BIT     = 5;
  localparam int CCW_BIT    = 4;
  localparam int ORIENT_BIT = 2;

  // status byte fields
  localparam int SPEED_REACHED_BIT = 4;
  localparam int ORIENT_DONE_BIT   = 2;

  // reset values
  localparam logic [7:0] COMMAND_FLAGS_RESET = 8'h00;
  localparam logic [7:0] STATUS_FLAGS_RESET  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;

  // what the controller asks of one servo drive over its bus
  typedef struct packed {
    logic orient;
    logic ccw;
    logic cw;
  } servo_cmd_t;

  localparam servo_cmd_t SERVO_CMD_RESET = '{orient: 1'b0, ccw: 1'b0,
                                              cw: 1'b0};

  // what one servo drive reports back over the bus
  typedef struct packed {
    logic speed_at_target;
    logic orient_complete;
  } servo_fb_t;

  typedef enum logic [2:0] {
    ST_STOP,
    ST_CW,
    ST_CCW,
    ST_ORIENT,
    ST_ORIENTED
  } spindle_mode_t;

endpackage

// File: core/spindle_channel.sv
// per-spindle command decode, orientation sequence and status flags
`timescale 1ns/1ps
`default_nettype none

module spindle_channel #(
  parameter bit SERIAL = 1'b1
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // ladder side
  input  wire logic [7:0]                  command_flags,
  output logic      [7:0]                  status_flags,
  // servo drive side
  input  wire spindle_flag_pkg::servo_fb_t fb,
  output spindle_flag_pkg::servo_cmd_t     drive
);

  typedef struct packed {
    spindle_flag_pkg::spindle_mode_t mode;
    spindle_flag_pkg::servo_cmd_t    drive;
    logic [7:0]                      status;
  } chan_state_t;

  chan_state_t state_reg;
  chan_state_t state_next;
  logic        cw_bit;
  logic        ccw_bit;
  logic        orient_bit;

  assign cw_bit     = command_flags[spindle_flag_pkg::CW_BIT];
  assign ccw_bit    = command_flags[spindle_flag_pkg::CCW_BIT];
  assign orient_bit = command_flags[spindle_flag_pkg::ORIENT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    if (orient_bit && SERIAL) begin
      case (state_reg.mode)
        spindle_flag_pkg::ST_ORIENT: begin
          if (fb.orient_complete) begin
            state_next.mode = spindle_flag_pkg::ST_ORIENTED;
          end
        end
        spindle_flag_pkg::ST_ORIENTED: begin
          // finished flag stays up until the ladder drops the start bit
          state_next.mode = spindle_flag_pkg::ST_ORIENTED;
        end
        spindle_flag_pkg::ST_STOP,
        spindle_flag_pkg::ST_CW,
        spindle_flag_pkg::ST_CCW: begin
          state_next.mode = spindle_flag_pkg::ST_ORIENT;
        end
        default: state_next.mode = spindle_flag_pkg::ST_STOP;
      endcase
    end else if (cw_bit && !ccw_bit) begin
      // direction is decoded at once, also when an orientation is released
      state_next.mode = spindle_flag_pkg::ST_CW;
    end else if (ccw_bit && !cw_bit) begin
      state_next.mode = spindle_flag_pkg::ST_CCW;
    end else begin
      // both directions at once is a ladder fault: stop, safest choice
      state_next.mode = spindle_flag_pkg::ST_STOP;
    end
    // speed and direction while orienting come from the drive's own setup
    state_next.drive.cw     = state_next.mode == spindle_flag_pkg::ST_CW;
    state_next.drive.ccw    = state_next.mode == spindle_flag_pkg::ST_CCW;
    state_next.drive.orient = state_next.mode == spindle_flag_pkg::ST_ORIENT;
    state_next.status = spindle_flag_pkg::STATUS_FLAGS_RESET;
    state_next.status[spindle_flag_pkg::SPEED_REACHED_BIT] =
      (state_next.drive.cw || state_next.drive.ccw) &&
      fb.speed_at_target;
    state_next.status[spindle_flag_pkg::ORIENT_DONE_BIT] =
      state_next.mode == spindle_flag_pkg::ST_ORIENTED;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg.mode   <= spindle_flag_pkg::ST_STOP;
      state_reg.drive  <= spindle_flag_pkg::SERVO_CMD_RESET;
      state_reg.status <= spindle_flag_pkg::STATUS_FLAGS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign drive        = state_reg.drive;
  assign status_flags = state_reg.status;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_orient_running;
    drive.orient && orient_bit && fb.orient_complete;
  endsequence

  sequence s_orient_finished;
    status_flags[spindle_flag_pkg::ORIENT_DONE_BIT] && !drive.orient;
  endsequence

  chk_cw_drive: assert property (
    cw_bit && !ccw_bit && !orient_bit |=> drive.cw && !drive.ccw)
    else $error("clockwise command not driven");

  chk_ccw_drive: assert property (
    ccw_bit && !cw_bit && !orient_bit |=> drive.ccw && !drive.cw)
    else $error("counter-clockwise command not driven");

  chk_speed_flag: assert property (
    status_flags[spindle_flag_pkg::SPEED_REACHED_BIT] |->
      $past(fb.speed_at_target) && (drive.cw || drive.ccw))
    else $error("speed flag without arrival");

  chk_orient_serial: assert property (
    drive.orient |-> SERIAL)
    else $error("orientation on a non-serial spindle");

  chk_orient_start: assert property (
    orient_bit && SERIAL && !drive.orient &&
    !status_flags[spindle_flag_pkg::ORIENT_DONE_BIT] |=>
      drive.orient && !drive.cw && !drive.ccw)
    else $error("orientation start not taken");

  chk_orient_done: assert property (
    s_orient_running |=> s_orient_finished)
    else $error("orientation finish not flagged");

  chk_done_hold: assert property (
    status_flags[spindle_flag_pkg::ORIENT_DONE_BIT] && orient_bit
      |=> status_flags[spindle_flag_pkg::ORIENT_DONE_BIT] [*2]
      or !orient_bit)
    else $error("finish flag dropped while start held");

  chk_done_release: assert property (
    !orient_bit |=> !status_flags[spindle_flag_pkg::ORIENT_DONE_BIT])
    else $error("finish flag stuck after release");

endmodule

`default_nettype wire

// File: core/serial_spindle_flag_interface.sv
// serial spindle flag interface: command and status bytes for three spindles
`timescale 1ns/1ps
`default_nettype none

module serial_spindle_flag_interface #(
  parameter int         SPINDLE_COUNT = spindle_flag_pkg::SERIAL_SPINDLE_MAX,
  parameter logic [2:0] SERIAL_MASK   = 3'h7
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             sys_rst,
  // ladder command byte writes
  input  wire logic                             wr_en,
  input  wire logic [7:0]                       wr_idx,
  input  wire logic [7:0]                       wr_data,
  // ladder byte reads
  input  wire logic                             rd_space,
  input  wire logic [7:0]                       rd_idx,
  output logic      [7:0]                       rd_data,
  // servo bus, one entry per spindle
  input  wire spindle_flag_pkg::servo_fb_t [2:0] servo_fb,
  output spindle_flag_pkg::servo_cmd_t [2:0]    servo_cmd
);

  typedef struct packed {
    logic [2:0][7:0] command;
    logic [7:0]      rd_data;
  } top_state_t;

  top_state_t      state_reg;
  top_state_t      state_next;
  logic [2:0][7:0] status_bytes;

  // byte indices follow the ladder's own map, not a dense range
  function automatic logic [1:0] cmd_slot(input logic [7:0] idx);
    case (idx)
      spindle_flag_pkg::SPINDLE1_COMMAND_FLAGS_IDX: cmd_slot = 2'h0;
      spindle_flag_pkg::SPINDLE2_COMMAND_FLAGS_IDX: cmd_slot = 2'h1;
      spindle_flag_pkg::SPINDLE3_COMMAND_FLAGS_IDX: cmd_slot = 2'h2;
      default:                                      cmd_slot = 2'h3;
    endcase
  endfunction

  function automatic logic [1:0] status_slot(input logic [7:0] idx);
    case (idx)
      spindle_flag_pkg::SPINDLE1_STATUS_FLAGS_IDX: status_slot = 2'h0;
      spindle_flag_pkg::SPINDLE2_STATUS_FLAGS_IDX: status_slot = 2'h1;
      spindle_flag_pkg::SPINDLE3_STATUS_FLAGS_IDX: status_slot = 2'h2;
      default:                                     status_slot = 2'h3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [1:0] wslot;
    logic [1:0] rslot;
    wslot = cmd_slot(wr_idx);
    rslot = 2'h3;
    state_next = state_reg;
    // spindles past the configured count keep their bytes at reset value
    if (wr_en && wslot != 2'h3 && int'(wslot) < SPINDLE_COUNT) begin
      state_next.command[wslot] = wr_data;
    end
    state_next.rd_data = spindle_flag_pkg::UNMAPPED_READ;
    if (rd_space == spindle_flag_pkg::SPACE_COMMAND) begin
      rslot = cmd_slot(rd_idx);
      if (rslot != 2'h3) begin
        state_next.rd_data = state_reg.command[rslot];
      end
    end else begin
      rslot = status_slot(rd_idx);
      if (rslot != 2'h3) begin
        state_next.rd_data = status_bytes[rslot];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg.command <= {3{spindle_flag_pkg::COMMAND_FLAGS_RESET}};
      state_reg.rd_data <= spindle_flag_pkg::UNMAPPED_READ;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data = state_reg.rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // three channels; an analog spindle is a channel with SERIAL clear
  for (genvar i = 0; i < 3; i++) begin : g_spindle
    spindle_channel #(
      .SERIAL (SERIAL_MASK[i])
    ) u_channel (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .command_flags (state_reg.command[i]),
      .status_flags  (status_bytes[i]),
      .fb            (servo_fb[i]),
      .drive         (servo_cmd[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_status_read: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_space == spindle_flag_pkg::SPACE_STATUS &&
    rd_idx == spindle_flag_pkg::SPINDLE1_STATUS_FLAGS_IDX
      |=> rd_data == $past(status_bytes[0]))
    else $error("status byte read mismatch");

  chk_cmd_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_en && wr_idx == spindle_flag_pkg::SPINDLE2_COMMAND_FLAGS_IDX &&
    SPINDLE_COUNT > 1 && wr_data[spindle_flag_pkg::CW_BIT] &&
    !wr_data[spindle_flag_pkg::CCW_BIT] &&
    !wr_data[spindle_flag_pkg::ORIENT_BIT]
      |=> ##1 servo_cmd[1].cw)
    else $error("written command did not reach the drive");

  chk_analog_limit: assert property (
    @(posedge clk) disable iff (sys_rst)
    3 - $countones(SERIAL_MASK) <= spindle_flag_pkg::ANALOG_SPINDLE_MAX)
    else $error("more analog spindles than allowed");

endmodule

`default_nettype wire

// File: dv/servo_drive_model.sv
// behavioural serial servo drive that answers spindle commands after a delay
`timescale 1ns/1ps
`default_nettype none

module servo_drive_model (
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               sys_rst,
  // answer delay in cycles, 0 answers promptly
  input  wire logic [3:0]                         delay,
  // servo bus
  input  wire spindle_flag_pkg::servo_cmd_t [2:0] cmd,
  output spindle_flag_pkg::servo_fb_t [2:0]       fb
);
  spindle_flag_pkg::servo_cmd_t [2:0] prev;
  logic [3:0]                         cnt [3];

  // any change of command restarts the drive, so stale feedback never lingers
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      prev[i] <= cmd[i];
      if (sys_rst || cmd[i] !== prev[i]) begin
        cnt[i] <= 4'h0;
        fb[i] <= '0;
      end else if (cnt[i] < delay) begin
        cnt[i] <= cnt[i] + 4'h1;
      end else begin
        fb[i].speed_at_target <= cmd[i].cw | cmd[i].ccw;
        fb[i].orient_complete <= cmd[i].orient;
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/serial_spindle_flag_interface_bench.sv
// self-checking bench of the serial spindle flag interface
`timescale 1ns/1ps
`default_nettype none

module serial_spindle_flag_interface_bench;
  // spindle2 analog, spindles 1 and 3 serial
  localparam logic [2:0] MASK = 3'h5;

  logic                               clk = 1'b0;
  logic                               sys_rst = 1'b1;
  logic                               wr_en = 1'b0;
  logic [7:0]                         wr_idx = 8'h00;
  logic [7:0]                         wr_data = 8'h00;
  logic                               rd_space = 1'b0;
  logic [7:0]                         rd_idx = 8'h00;
  logic [7:0]                         rd_data;
  logic [3:0]                         delay = 4'h0;
  spindle_flag_pkg::servo_fb_t [2:0]  servo_fb;
  spindle_flag_pkg::servo_cmd_t [2:0] servo_cmd;
  int                                 error_cnt = 0;
  int                                 n_compared = 0;
  logic [31:0]                        seed = 32'h4307;
  logic [7:0]                         got;
  logic [7:0] pats [6] = '{8'h20, 8'h10, 8'h30, 8'h04, 8'h24, 8'h00};
  logic [7:0] cidx [3] = '{8'h46, 8'h4A, 8'h4E};
  logic [7:0] sidx [3] = '{8'h2D, 8'h31, 8'h35};

  always #5 clk = ~clk;

  serial_spindle_flag_interface #(.SERIAL_MASK(MASK)) DUT (
    .clk(clk), .sys_rst(sys_rst), .wr_en(wr_en), .wr_idx(wr_idx),
    .wr_data(wr_data), .rd_space(rd_space), .rd_idx(rd_idx),
    .rd_data(rd_data), .servo_fb(servo_fb), .servo_cmd(servo_cmd));

  servo_drive_model drive (.clk(clk), .sys_rst(sys_rst), .delay(delay),
    .cmd(servo_cmd), .fb(servo_fb));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // orientation wins over direction; both directions at once means stop
  function automatic spindle_flag_pkg::servo_cmd_t exp_cmd(input int s,
                                                           input logic [7:0] d);
    spindle_flag_pkg::servo_cmd_t c;
    c.orient = d[2] & MASK[s];
    c.cw = ~c.orient & d[5] & ~d[4];
    c.ccw = ~c.orient & d[4] & ~d[5];
    return c;
  endfunction

  function automatic logic [7:0] exp_status(input int s, input logic [7:0] d);
    spindle_flag_pkg::servo_cmd_t c;
    c = exp_cmd(s, d);
    return c.orient ? 8'h04 : {3'h0, c.cw | c.ccw, 4'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_byte(input string n, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check_cmd(input string n,
                           input spindle_flag_pkg::servo_cmd_t e, g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic write_byte(input logic [7:0] i, d);
    @(posedge clk);
    #1 wr_en = 1'b1;
    wr_idx = i;
    wr_data = d;
    @(posedge clk);
    #1 wr_en = 1'b0;
  endtask

  task automatic read_byte(input logic sp, input logic [7:0] i);
    @(posedge clk);
    #1 rd_space = sp;
    rd_idx = i;
    @(posedge clk);
    #1 got = rd_data;
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int         s;
    logic [7:0] d;
    logic [7:0] r;
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      read_byte(1'b0, cidx[i]);
      check_byte("command byte", 8'h00, got);
      read_byte(1'b1, sidx[i]);
      check_byte("status byte", 8'h00, got);
      check_cmd("servo cmd", 3'b000, servo_cmd[i]);
    end
    $display("test reset values done");
    for (int n = 0; n < 36; n++) begin
      seed = xorshift(seed);
      s = (n + n / 6) % 3;
      d = pats[n % 6] | (seed[7:0] & 8'hCB);
      delay = (n < 6) ? 4'h0 : seed[11:8];
      write_byte(cidx[s], d);
      repeat (2) @(posedge clk);
      #1 check_cmd("servo cmd", exp_cmd(s, d), servo_cmd[s]);
      repeat (24) @(posedge clk);
      read_byte(1'b1, sidx[s]);
      check_byte("status byte", exp_status(s, d), got);
      read_byte(1'b0, cidx[s]);
      check_byte("command byte", d, got);
      if (exp_status(s, d) == 8'h04) begin
        // release orientation but keep the direction bits of the word
        r = d & 8'h30;
        write_byte(cidx[s], r);
        repeat (2) @(posedge clk);
        #1 check_cmd("servo cmd", exp_cmd(s, r), servo_cmd[s]);
        read_byte(1'b1, sidx[s]);
        check_byte("status byte", 8'h00, got);
      end
    end
    $display("test spindle commands done");
    write_byte(8'h47, seed[15:8]);
    read_byte(1'b0, 8'h47);
    check_byte("unmapped read", 8'h00, got);
    read_byte(1'b1, cidx[0]);
    check_byte("unmapped read", 8'h00, got);
    $display("test unmapped bytes done");
    finish_test;
  end

  // the whole run needs about 1250 cycles
  initial begin
    #200us;
    error_cnt++;
    $display("watchdog expired");
    finish_test;
  end
endmodule
`default_nettype wire
